// ### common/ltip_pkg.sv
// Constants and carrier types for the line transmit input port.
// Assumes a 100 MHz sys_clk, synchronous active-high srst, AXI4-Lite registers.
package ltip_pkg;

	// Register map, byte addresses
	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  REG_CTRL        = 8'h00;
	localparam logic [7:0]  REG_STATUS      = 8'h04;
	localparam logic [7:0]  REG_OVERRUN     = 8'h08;
	localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
	localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

	// Control fields
	localparam int CTRL_EDGE_RISE   = 0;
	localparam int CTRL_SINGLE_RAIL = 1;
	localparam int CTRL_HOST_MODE   = 2;
	localparam int CTRL_USED_W      = 3;

	// Status fields
	localparam int STAT_TX_ON      = 0;
	localparam int STAT_HOST_MODE  = 1;
	localparam int STAT_EDGE_RISE  = 2;
	localparam int STAT_LEVEL_LSB  = 4;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Pin synchroniser layout
	localparam int SYNC_STAGES = 3;
	localparam int NUM_PINS    = 5;
	localparam int PIN_CLK     = 0;
	localparam int PIN_POS     = 1;
	localparam int PIN_NEG     = 2;
	localparam int PIN_SEL     = 3;
	localparam int PIN_ON      = 4;

	// Sample buffer
	localparam int FIFO_WIDTH = 2;
	localparam int FIFO_DEPTH = 8;
	localparam int LEVEL_W    = 4;
	localparam int OVR_W      = 16;
	localparam int SAMPLE_POS = 1;
	localparam int SAMPLE_NEG = 0;

	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} ltip_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} ltip_axi_rsp_t;

	typedef struct packed {
		logic a;
		logic b;
		logic oe_n;
	} ltip_line_t;

endpackage : ltip_pkg

// ### logic/ltip_fifo.sv
// Sample buffer between the rail sampler and the line driver.
// Assumes both sides run on sys_clk; pushes and pops may share a cycle.
`timescale 1ns/1ps
module ltip_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             srst,
	// Filling side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// Draining side
	output logic                  out_valid,
	output logic [WIDTH-1:0]      out_data,
	input  wire logic             out_ready,
	// Fill level
	output logic [$clog2(DEPTH):0] level
);
	import ltip_pkg::*;

	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wr;
		logic [PW-1:0]               rd;
		logic [PW:0]                 cnt;
	} ltip_fifo_state_t;

	ltip_fifo_state_t st;
	ltip_fifo_state_t next_st;
	logic             do_push;
	logic             do_pop;

	assign in_ready  = (st.cnt != DEPTH[PW:0]);
	assign out_valid = (st.cnt != '0);
	assign out_data  = st.mem[st.rd];
	assign level     = st.cnt;
	assign do_push   = in_valid && in_ready;
	assign do_pop    = out_valid && out_ready;

	always_comb begin
		next_st = st;
		if (do_push) begin
			next_st.mem[st.wr] = in_data;
			next_st.wr         = (st.wr == PW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
		end
		if (do_pop) begin
			next_st.rd = (st.rd == PW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
		end
		case ({do_push, do_pop})
			2'b10:   next_st.cnt = st.cnt + 1'b1;
			2'b01:   next_st.cnt = st.cnt - 1'b1;
			default: next_st.cnt = st.cnt;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule : ltip_fifo

// ### logic/ltip_main.sv
// Transmit input port: samples rail data on the chosen link clock edge,
// buffers it and drives a bipolar, tri-statable line pair.
// Assumes the link clock and rails are asynchronous pins, far slower than sys_clk.
`timescale 1ns/1ps
module ltip_main (
	// Clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   srst,
	// Register bus
	input  wire ltip_pkg::ltip_axi_req_t axi_req,
	output ltip_pkg::ltip_axi_rsp_t      axi_rsp,
	// Link pins
	input  wire logic                   transmit_clock_input,
	input  wire logic                   positive_rail_input,
	input  wire logic                   negative_rail_input,
	input  wire logic                   transmit_edge_select,
	input  wire logic                   transmitter_on_input,
	// Line pair
	output ltip_pkg::ltip_line_t         line_out,
	// Serial interface clock in host mode
	output logic                        serial_clock_out
);
	import ltip_pkg::*;

	typedef struct packed {
		logic [NUM_PINS-1:0][SYNC_STAGES-1:0] sync;
		logic [NUM_PINS-1:0]                  filt;
		logic                                 clk_prev;
		logic [31:0]                          ctrl;
		logic [OVR_W-1:0]                     overrun;
		logic                                 ami_neg;
		logic                                 push_valid;
		logic [FIFO_WIDTH-1:0]                push_data;
		ltip_line_t                           line;
		logic                                 sclk;
		logic                                 aw_held;
		logic [ADDR_W-1:0]                    aw_addr;
		logic                                 w_held;
		logic [31:0]                          wdata;
		logic [3:0]                           wstrb;
		ltip_axi_rsp_t                        rsp;
	} ltip_main_state_t;

	ltip_main_state_t          st;
	ltip_main_state_t          next_st;
	logic                      fifo_in_ready;
	logic                      fifo_out_valid;
	logic [FIFO_WIDTH-1:0]     fifo_out_data;
	logic                      fifo_out_ready;
	logic [$clog2(FIFO_DEPTH):0] fifo_level;
	logic                      host_mode;
	logic                      edge_rise;
	logic                      clk_rise;
	logic                      clk_fall;
	logic                      sample_edge;
	logic                      return_edge;
	logic                      tx_on;

	function automatic logic addr_is(input logic [ADDR_W-1:0] addr, input logic [7:0] reg_addr);
		addr_is = (addr == reg_addr);
	endfunction : addr_is

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
		addr_mapped = addr_is(addr, REG_CTRL) || addr_is(addr, REG_STATUS)
			|| addr_is(addr, REG_OVERRUN);
	endfunction : addr_mapped

	assign host_mode   = st.ctrl[CTRL_HOST_MODE];
	// Pin picks the edge in hardware mode, register bit in host mode
	assign edge_rise   = host_mode ? st.ctrl[CTRL_EDGE_RISE] : st.filt[PIN_SEL];
	assign clk_rise    = st.filt[PIN_CLK] && !st.clk_prev;
	assign clk_fall    = !st.filt[PIN_CLK] && st.clk_prev;
	assign sample_edge = edge_rise ? clk_rise : clk_fall;
	assign return_edge = edge_rise ? clk_fall : clk_rise;
	// Pin alone gates the driver, whatever the control mode
	assign tx_on       = st.filt[PIN_ON];

	// Line stage pops one sample per selected edge while transmitting
	assign fifo_out_ready = sample_edge && tx_on;

	ltip_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.srst      (srst),
		.in_valid  (st.push_valid),
		.in_data   (st.push_data),
		.in_ready  (fifo_in_ready),
		.out_valid (fifo_out_valid),
		.out_data  (fifo_out_data),
		.out_ready (fifo_out_ready),
		.level     (fifo_level)
	);

	always_comb begin
		logic [ADDR_W-1:0] rd_addr;
		logic [31:0]       rd_data;
		logic              wr_go;
		next_st = st;
		rd_addr = axi_req.araddr;
		rd_data = READ_ZERO;
		wr_go   = 1'b0;

		// Three-stage synchronisers; filtered level moves when stages two and three agree
		for (int p = 0; p < NUM_PINS; p++) begin
			next_st.sync[p] = {st.sync[p][SYNC_STAGES-2:0], 1'b0};
			if (st.sync[p][SYNC_STAGES-1] == st.sync[p][SYNC_STAGES-2]) begin
				next_st.filt[p] = st.sync[p][SYNC_STAGES-1];
			end
		end
		next_st.sync[PIN_CLK][0] = transmit_clock_input;
		next_st.sync[PIN_POS][0] = positive_rail_input;
		next_st.sync[PIN_NEG][0] = negative_rail_input;
		next_st.sync[PIN_SEL][0] = transmit_edge_select;
		next_st.sync[PIN_ON][0]  = transmitter_on_input;
		next_st.clk_prev         = st.filt[PIN_CLK];

		// Edge select pin doubles as serial clock in host mode
		next_st.sclk = host_mode ? st.filt[PIN_SEL] : 1'b0;

		// Rail capture on the selected edge
		next_st.push_valid = sample_edge;
		if (sample_edge) begin
			next_st.push_data[SAMPLE_POS] = st.filt[PIN_POS];
			// Negative rail only counts in dual-rail mode
			next_st.push_data[SAMPLE_NEG] = st.ctrl[CTRL_SINGLE_RAIL]
				? 1'b0 : st.filt[PIN_NEG];
		end
		if (st.push_valid && !fifo_in_ready) begin
			next_st.overrun = (st.overrun == '1) ? st.overrun : st.overrun + 1'b1;
		end

		// Line driver
		if (!tx_on) begin
			next_st.line.a    = 1'b0;
			next_st.line.b    = 1'b0;
			next_st.line.oe_n = 1'b1;
		end else begin
			next_st.line.oe_n = 1'b0;
			if (fifo_out_ready && fifo_out_valid) begin
				if (st.ctrl[CTRL_SINGLE_RAIL]) begin
					// Single rail: marks alternate polarity
					next_st.line.a = fifo_out_data[SAMPLE_POS] && !st.ami_neg;
					next_st.line.b = fifo_out_data[SAMPLE_POS] && st.ami_neg;
					if (fifo_out_data[SAMPLE_POS]) begin
						next_st.ami_neg = !st.ami_neg;
					end
				end else begin
					// Opposite rails give opposite pulses; both or neither give none
					next_st.line.a = fifo_out_data[SAMPLE_POS]
						&& !fifo_out_data[SAMPLE_NEG];
					next_st.line.b = fifo_out_data[SAMPLE_NEG]
						&& !fifo_out_data[SAMPLE_POS];
				end
			end else if (return_edge) begin
				next_st.line.a = 1'b0;
				next_st.line.b = 1'b0;
			end
		end

		// Write address and data, taken in either order
		if (axi_req.awvalid && st.rsp.awready) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && st.rsp.wready) begin
			next_st.w_held = 1'b1;
			next_st.wdata  = axi_req.wdata;
			next_st.wstrb  = axi_req.wstrb;
		end
		if (st.rsp.bvalid && axi_req.bready) begin
			next_st.rsp.bvalid = 1'b0;
		end
		wr_go = st.aw_held && st.w_held && !st.rsp.bvalid;
		if (wr_go) begin
			next_st.aw_held    = 1'b0;
			next_st.w_held     = 1'b0;
			next_st.rsp.bvalid = 1'b1;
			next_st.rsp.bresp  = RESP_OKAY;
			if (addr_is(st.aw_addr, REG_CTRL)) begin
				for (int b = 0; b < 4; b++) begin
					if (st.wstrb[b]) begin
						next_st.ctrl[b*8 +: 8] = st.wdata[b*8 +: 8];
					end
				end
				next_st.ctrl[31:CTRL_USED_W] = '0;
			end else if (addr_is(st.aw_addr, REG_OVERRUN)) begin
				// Any write clears; a drop in the same cycle still counts
				next_st.overrun = (st.push_valid && !fifo_in_ready) ? OVR_W'(1) : '0;
			end else begin
				next_st.rsp.bresp = RESP_SLVERR;
			end
		end
		next_st.rsp.awready = !next_st.aw_held && !next_st.rsp.bvalid;
		next_st.rsp.wready  = !next_st.w_held && !next_st.rsp.bvalid;

		// Read channel
		if (st.rsp.rvalid && axi_req.rready) begin
			next_st.rsp.rvalid = 1'b0;
		end
		if (axi_req.arvalid && st.rsp.arready) begin
			if (addr_is(rd_addr, REG_CTRL)) begin
				rd_data = st.ctrl;
			end else if (addr_is(rd_addr, REG_STATUS)) begin
				rd_data[STAT_TX_ON]     = tx_on;
				rd_data[STAT_HOST_MODE] = host_mode;
				rd_data[STAT_EDGE_RISE] = edge_rise;
				rd_data[STAT_LEVEL_LSB +: LEVEL_W] = fifo_level;
			end else if (addr_is(rd_addr, REG_OVERRUN)) begin
				rd_data[OVR_W-1:0] = st.overrun;
			end
			next_st.rsp.rvalid = 1'b1;
			next_st.rsp.rdata  = rd_data;
			next_st.rsp.rresp  = addr_mapped(rd_addr) ? RESP_OKAY : RESP_SLVERR;
		end
		next_st.rsp.arready = !next_st.rsp.rvalid;
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			// Undriven enable pin treated as off until sampled high
			st      <= '0;
			st.ctrl <= CTRL_RESET;
			st.line <= '{a: 1'b0, b: 1'b0, oe_n: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	assign axi_rsp          = st.rsp;
	assign line_out         = st.line;
	assign serial_clock_out = st.sclk;

endmodule : ltip_main

// ### tb/ltip_monitor.sv
// Checker for the transmit input port top level.
// Bound to ltip_main; sees its ports only.
`timescale 1ns/1ps
module ltip_monitor (
	input wire logic                    sys_clk,
	input wire logic                    srst,
	input wire ltip_pkg::ltip_axi_req_t axi_req,
	input wire ltip_pkg::ltip_axi_rsp_t axi_rsp,
	input wire logic                    transmitter_on_input,
	input wire ltip_pkg::ltip_line_t    line_out
);
	import ltip_pkg::*;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	sequence wr_taken;
		axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
	endsequence
	sequence rd_taken;
		axi_req.arvalid && axi_rsp.arready;
	endsequence
	chk_pair_exclusive: assert property (!(line_out.a && line_out.b))
		else $error("line pair driven both ways");
	chk_off_quiet: assert property (line_out.oe_n |-> !line_out.a && !line_out.b)
		else $error("line driven while released");
	chk_off_follow: assert property (!transmitter_on_input [*8] |-> line_out.oe_n)
		else $error("line not released when off");
	chk_on_follow: assert property (transmitter_on_input [*8] |-> !line_out.oe_n)
		else $error("line not driven when on");
	chk_pulse_on: assert property (($rose(line_out.a) || $rose(line_out.b)) |-> !line_out.oe_n)
		else $error("pulse while released");
	chk_write_answer: assert property (wr_taken |-> ##[1:2] axi_rsp.bvalid)
		else $error("write response late");
	chk_read_answer: assert property (rd_taken |=> axi_rsp.rvalid)
		else $error("read response late");
	chk_unmapped_err: assert property ((rd_taken ##0 axi_req.araddr == 8'h0C)
		|=> axi_rsp.rresp == RESP_SLVERR)
		else $error("unmapped read not refused");
endmodule : ltip_monitor
bind ltip_main ltip_monitor mon (.sys_clk, .srst, .axi_req, .axi_rsp,
	.transmitter_on_input, .line_out);

// ### tb/ltip_link_model.sv
// Far-end terminal model: link clock and rail data in frames.
// Clock stands low between frames; rails invert on release.
`timescale 1ns/1ps
module ltip_link_model (
	output logic link_clk,
	output logic pos,
	output logic neg
);
	initial begin
		link_clk = 1'b0;
		pos      = 1'b0;
		neg      = 1'b0;
	end
	// One bit per 125 ns: rising-edge value, then falling-edge value
	task automatic send(input logic [15:0] pr, nr, pf, nf);
		// Step off the sys_clk rising edges
		#1;
		for (int i = 15; i >= 0; i--) begin
			pos = pr[i];
			neg = nr[i];
			#31.25 link_clk = 1'b1;
			#31.25 pos = pf[i];
			neg = nf[i];
			#31.25 link_clk = 1'b0;
			#31.25;
		end
		pos = ~pos;
		neg = ~neg;
	endtask : send
endmodule : ltip_link_model

// ### tb/tb.sv
// Top-level bench for the transmit input port.
// Registers over AXI4-Lite; link clock and rails from the far-end model, edge select and enable from the bench.
`timescale 1ns/1ps
module tb;
	import ltip_pkg::*;
	logic          sys_clk   = 1'b0;
	logic          srst      = 1'b1;
	ltip_axi_req_t axi_req   = '0;
	ltip_axi_rsp_t axi_rsp;
	ltip_line_t    line_out;
	logic          tx_on     = 1'b0;
	logic          sel       = 1'b0;
	logic          sclk_out;
	logic          lclk;
	logic          lp;
	logic          ln;
	logic          pa        = 1'b0;
	logic          pb        = 1'b0;
	int            na        = 0;
	int            nb        = 0;
	int            error_cnt = 0;
	int            compares  = 0;
	logic [31:0]   rd;
	logic [1:0]    rs;

	always #5 sys_clk = ~sys_clk;
	ltip_link_model link (.link_clk(lclk), .pos(lp), .neg(ln));
	ltip_main dut (
		.sys_clk(sys_clk), .srst(srst), .axi_req(axi_req), .axi_rsp(axi_rsp),
		.transmit_clock_input(lclk), .positive_rail_input(lp),
		.negative_rail_input(ln), .transmit_edge_select(sel),
		.transmitter_on_input(tx_on), .line_out(line_out), .serial_clock_out(sclk_out));

	// Pulse counters on the line pair
	always @(posedge sys_clk) begin
		pa <= line_out.a;
		pb <= line_out.b;
		if (line_out.a === 1'b1 && pa === 1'b0)
			na <= na + 1;
		if (line_out.b === 1'b1 && pb === 1'b0)
			nb <= nb + 1;
	end

	task automatic chk(input string nm, input logic [31:0] got, want);
		compares++;
		if (got !== want) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, want, got);
		end
	endtask : chk

	task automatic summarize();
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	task automatic do_reset();
		srst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask : do_reset

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge sys_clk);
		axi_req.awaddr  <= ad;
		axi_req.awvalid <= 1'b1;
		axi_req.wdata   <= d;
		axi_req.wvalid  <= 1'b1;
		axi_req.wstrb   <= 4'hF;
		axi_req.bready  <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (axi_rsp.awready)
				axi_req.awvalid <= 1'b0;
			if (axi_rsp.wready)
				axi_req.wvalid <= 1'b0;
		end while (axi_rsp.bvalid !== 1'b1);
		axi_req.bready <= 1'b0;
		rs = axi_rsp.bresp;
	endtask : wr

	task automatic rdreg(input logic [7:0] ad);
		@(posedge sys_clk);
		axi_req.araddr  <= ad;
		axi_req.arvalid <= 1'b1;
		axi_req.rready  <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (axi_rsp.arready)
				axi_req.arvalid <= 1'b0;
		end while (axi_rsp.rvalid !== 1'b1);
		axi_req.rready <= 1'b0;
		rd = axi_rsp.rdata;
		rs = axi_rsp.rresp;
	endtask : rdreg

	task automatic frame(input logic [15:0] pr, nr, pf, nf, input int ea, eb);
		int a0;
		int b0;
		repeat (10) @(posedge sys_clk);
		a0 = na;
		b0 = nb;
		link.send(pr, nr, pf, nf);
		repeat (30) @(posedge sys_clk);
		chk("a pulses", 32'(na - a0), 32'(ea));
		chk("b pulses", 32'(nb - b0), 32'(eb));
	endtask : frame

	initial begin
		#100000;
		error_cnt++;
		summarize();
	end

	initial begin
		do_reset();
		chk("oe_n idle", 32'(line_out.oe_n), 32'h1);
		rdreg(REG_CTRL);
		chk("ctrl reset", rd, CTRL_RESET);
		chk("ctrl resp", 32'(rs), 32'(RESP_OKAY));
		rdreg(REG_STATUS);
		chk("status idle", rd, 32'h0);
		rdreg(8'h0C);
		chk("unmapped resp", 32'(rs), 32'(RESP_SLVERR));
		chk("unmapped data", rd, READ_ZERO);
		wr(REG_STATUS, 32'hFFFF_FFFF);
		chk("status write", 32'(rs), 32'(RESP_SLVERR));
		tx_on <= 1'b1;
		sel <= 1'b1;
		frame(16'hCA00, 16'h5600, 16'hFF00, 16'h0000, 2, 2);
		chk("sclk hw", 32'(sclk_out), 32'h0);
		sel <= 1'b0;
		frame(16'hFF00, 16'h0000, 16'hCA00, 16'h5600, 2, 2);
		do_reset();
		sel <= 1'b1;
		wr(REG_CTRL, 32'h2);
		chk("ctrl write resp", 32'(rs), 32'(RESP_OKAY));
		frame(16'hE000, 16'hFFFF, 16'h0000, 16'hFFFF, 2, 1);
		wr(REG_CTRL, 32'h5);
		sel <= 1'b0;
		frame(16'hCA00, 16'h5600, 16'hFF00, 16'h0000, 2, 2);
		rdreg(REG_STATUS);
		chk("status host", rd & 32'h7, 32'h7);
		for (int i = 1; i >= 0; i--) begin
			sel <= i[0];
			repeat (8) @(posedge sys_clk);
			chk("sclk host", 32'(sclk_out), 32'(i));
		end
		wr(REG_CTRL, 32'h4);
		sel <= 1'b1;
		frame(16'hFF00, 16'h0000, 16'hCA00, 16'h5600, 2, 2);
		tx_on <= 1'b0;
		do_reset();
		wr(REG_CTRL, 32'h5);
		frame(16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 0, 0);
		chk("oe_n off", 32'(line_out.oe_n), 32'h1);
		rdreg(REG_OVERRUN);
		chk("overrun", rd, 32'h8);
		rdreg(REG_STATUS);
		chk("status full", rd, 32'h86);
		wr(REG_OVERRUN, 32'h1);
		rdreg(REG_OVERRUN);
		chk("overrun clear", rd, 32'h0);
		tx_on <= 1'b1;
		frame(16'h0000, 16'h0000, 16'h0000, 16'h0000, 8, 0);
		summarize();
	end
endmodule : tb
